// ### start_seq_map.svh
// register offsets, reset values, limits and timing for the start sequencer
`ifndef START_SEQ_MAP_SVH
`define START_SEQ_MAP_SVH
`define OFS_CFG        12'h000
`define OFS_START_FREQ 12'h004
`define OFS_HOLD       12'h008
`define OFS_BRK_CUR    12'h00C
`define OFS_BRK_TIME   12'h010
`define OFS_S_ACC_BEG  12'h014
`define OFS_S_ACC_END  12'h018
`define OFS_S_DEC_BEG  12'h01C
`define OFS_S_DEC_END  12'h020
`define OFS_ACC_TIME   12'h024
`define OFS_DEC_TIME   12'h028
`define OFS_TARGET     12'h02C
`define OFS_RUN        12'h030
`define OFS_STATUS     12'h034
`define OFS_OUT_FREQ   12'h038
`define CFG_METHOD_LSB 0
`define CFG_SHAPE_BIT  4
`define RUN_BIT        0
`define STAT_BRK_BIT   8
`define STAT_TRK_BIT   9
`define DEF_START_FREQ 16'h0032
`define DEF_HOLD       16'h0000
`define DEF_BRK_CUR    16'h0000
`define DEF_BRK_TIME   16'h0000
`define DEF_SEG        16'h0001
`define DEF_RAMP_TIME  16'h0064
`define MAX_START_FREQ 16'h1388
`define MAX_HOLD       16'h01F4
`define MAX_BRK_CUR    16'h03E8
`define MAX_BRK_TIME   16'h1388
`define MAX_SEG        16'h01F4
`define MAX_RAMP_TIME  16'h8CA0
`define DEF_MAX_FREQ   16'h1388
`define CLK_PERIOD_NS  10
`define FAST_TICK_NS   100000
`define SLOW_TICK_NS   10000000
`define HOLD_UNIT      16'h000A
`define RAMP_UNIT      16'h03E8
`define SCALE_FULL     9'h100
`define SCALE_MIN      9'h010
`endif

// ### start_seq_pkg.sv
// types shared by the start sequencer files
package start_seq_pkg;
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_STANDBY = 7'h02,
    ST_BRAKE   = 7'h04,
    ST_TRACK   = 7'h08,
    ST_HOLD    = 7'h10,
    ST_RAMP    = 7'h20,
    ST_RUN     = 7'h40
  } state_t;
  typedef enum logic [1:0] {
    M_DIRECT = 2'h0,
    M_BRAKE  = 2'h1,
    M_TRACK  = 2'h2
  } start_method_t;
endpackage

// ### step_if.sv
// carrier between the sequencer and one fractional rate stepper
`timescale 1ns/1ps
interface step_if #(parameter int W = 32);
  logic         tick;
  logic         clr;
  logic [W-1:0] inc;
  logic [W-1:0] period;
  logic         step;
  modport owner   (output tick, output clr, output inc, output period, input step);
  modport stepper (input tick, input clr, input inc, input period, output step);
endinterface

// ### rate_stepper.sv
// fractional accumulator: one step pulse per period/inc ticks
`timescale 1ns/1ps
module rate_stepper #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control and step pulse
  step_if.stepper   s
);
  logic [W-1:0] acc_ff;
  logic [W:0]   sum;

  assign sum = {1'b0, acc_ff} + {1'b0, s.inc};

  // at most one step per tick; a zero period steps on every tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= '0;
      s.step <= 1'b0;
    end else if (s.clr) begin
      acc_ff <= '0;
      s.step <= 1'b0;
    end else if (s.tick) begin
      if (sum >= {1'b0, s.period}) begin
        acc_ff <= W'(sum - {1'b0, s.period});
        s.step <= 1'b1;
      end else begin
        acc_ff <= sum[W-1:0];
        s.step <= 1'b0;
      end
    end else begin
      s.step <= 1'b0;
    end
  end
endmodule // rate_stepper

// ### drive_start_sequencer.sv
// start-phase sequencer for the drive output frequency, APB slave
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "start_seq_map.svh"
// Behaviour
// - start method 0 is direct start, 1 is DC braking first, 2 is speed tracking first; reset gives 0.
// - on a direct start the first output frequency is the programmed starting frequency (0.00-50.00 Hz, 0.50 Hz).
// - the output stays at the starting frequency for the hold time (0.0-50.0 s, 0.0 s), then ramps.
// - a target below the starting frequency keeps the sequencer in standby, never running; checked only at start, a target lowered later is ramped to.
// - the starting frequency is not clamped by any lower limit frequency.
// - braking first applies DC braking at the set current and accelerates only after the full brake time.
// - a brake time of zero skips DC braking altogether.
// - the brake current is a percentage of rated output current, 0.0-100.0 %, default 0.0 %.
// - the brake time accepts 0.00-50.00 s and defaults to 0.00 s.
// - ramp shape 0 (default) changes the frequency linearly with time.
// - ramp shape 1 changes the frequency along an S curve, easing in and out.
// - the S curve follows four segment times plus the acceleration and deceleration times.
// - each S segment time accepts 0.0-50.0 s and defaults to 0.1 s.
module drive_start_sequencer import start_seq_pkg::*; #(
  parameter logic [15:0] MAX_FREQ = `DEF_MAX_FREQ,
  parameter int unsigned FAST_CYC = `FAST_TICK_NS / `CLK_PERIOD_NS,
  parameter int unsigned SLOW_CYC = `SLOW_TICK_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // power stage
  input  wire logic        track_done,
  output logic [15:0]      out_freq,
  output logic             drive_en,
  output logic             brake_en,
  output logic [15:0]      brake_cur,
  output logic             track_req,
  output logic             standby
);
  state_t      state_ff, nxt_state;
  logic [1:0]  method_ff;
  logic        shape_ff, run_ff;
  logic [15:0] start_freq_ff, hold_ff, brk_cur_ff, brk_time_ff;
  logic [15:0] s_acc_beg_ff, s_acc_end_ff, s_dec_beg_ff, s_dec_end_ff;
  logic [15:0] acc_time_ff, dec_time_ff, target_ff;
  logic [31:0] prdata_ff, rd_data;
  logic        pready_ff, pslverr_ff, rd_hit;
  logic        trk_meta_ff, trk_sync_ff;
  logic [31:0] fast_div_ff, slow_div_ff;
  logic        fast_tick_ff, slow_tick;
  logic [15:0] phase_cnt_ff;
  logic        phase_new, brake_done, hold_done, go_ok;
  logic [15:0] out_freq_ff, brake_cur_ff, gain_ff, remaining;
  logic        drive_en_ff, brake_en_ff, track_req_ff, standby_ff;
  logic [8:0]  scale_ff;
  logic        dir_up_ff, ease_out_ff, dir_up, ramp_restart;
  logic [24:0] prod;
  logic [15:0] ramp_t, seg_t;
  logic        wr_en, setup;

  step_if #(.W(32)) fq_if ();
  step_if #(.W(32)) sc_if ();

  function automatic logic [15:0] sat(input logic [31:0] v, input logic [15:0] mx);
    sat = (v > {16'h0000, mx}) ? mx : v[15:0];
  endfunction

  // apb: one wait-free access phase, pready from a flop
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_ff && pwrite;

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (paddr)
      `OFS_CFG:        rd_data = {27'h0, shape_ff, 2'h0, method_ff};
      `OFS_START_FREQ: rd_data = {16'h0, start_freq_ff};
      `OFS_HOLD:       rd_data = {16'h0, hold_ff};
      `OFS_BRK_CUR:    rd_data = {16'h0, brk_cur_ff};
      `OFS_BRK_TIME:   rd_data = {16'h0, brk_time_ff};
      `OFS_S_ACC_BEG:  rd_data = {16'h0, s_acc_beg_ff};
      `OFS_S_ACC_END:  rd_data = {16'h0, s_acc_end_ff};
      `OFS_S_DEC_BEG:  rd_data = {16'h0, s_dec_beg_ff};
      `OFS_S_DEC_END:  rd_data = {16'h0, s_dec_end_ff};
      `OFS_ACC_TIME:   rd_data = {16'h0, acc_time_ff};
      `OFS_DEC_TIME:   rd_data = {16'h0, dec_time_ff};
      `OFS_TARGET:     rd_data = {16'h0, target_ff};
      `OFS_RUN:        rd_data = {31'h0, run_ff};
      `OFS_STATUS:     rd_data = {22'h0, track_req_ff, brake_en_ff, 1'b0, state_ff};
      `OFS_OUT_FREQ:   rd_data = {16'h0, out_freq_ff};
      default:         rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !rd_hit;
      if (setup) begin
        prdata_ff <= (pwrite || !rd_hit) ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // parameter writes saturate at the top of each documented range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      method_ff     <= M_DIRECT;
      shape_ff      <= 1'b0;
      run_ff        <= 1'b0;
      start_freq_ff <= `DEF_START_FREQ;
      hold_ff       <= `DEF_HOLD;
      brk_cur_ff    <= `DEF_BRK_CUR;
      brk_time_ff   <= `DEF_BRK_TIME;
      s_acc_beg_ff  <= `DEF_SEG;
      s_acc_end_ff  <= `DEF_SEG;
      s_dec_beg_ff  <= `DEF_SEG;
      s_dec_end_ff  <= `DEF_SEG;
      acc_time_ff   <= `DEF_RAMP_TIME;
      dec_time_ff   <= `DEF_RAMP_TIME;
      target_ff     <= 16'h0000;
    end else if (wr_en) begin
      unique case (paddr)
        `OFS_CFG: begin
          method_ff <= pwdata[`CFG_METHOD_LSB +: 2];
          shape_ff  <= pwdata[`CFG_SHAPE_BIT];
        end
        `OFS_START_FREQ: start_freq_ff <= sat(pwdata, `MAX_START_FREQ);
        `OFS_HOLD:       hold_ff       <= sat(pwdata, `MAX_HOLD);
        `OFS_BRK_CUR:    brk_cur_ff    <= sat(pwdata, `MAX_BRK_CUR);
        `OFS_BRK_TIME:   brk_time_ff   <= sat(pwdata, `MAX_BRK_TIME);
        `OFS_S_ACC_BEG:  s_acc_beg_ff  <= sat(pwdata, `MAX_SEG);
        `OFS_S_ACC_END:  s_acc_end_ff  <= sat(pwdata, `MAX_SEG);
        `OFS_S_DEC_BEG:  s_dec_beg_ff  <= sat(pwdata, `MAX_SEG);
        `OFS_S_DEC_END:  s_dec_end_ff  <= sat(pwdata, `MAX_SEG);
        `OFS_ACC_TIME:   acc_time_ff   <= sat(pwdata, `MAX_RAMP_TIME);
        `OFS_DEC_TIME:   dec_time_ff   <= sat(pwdata, `MAX_RAMP_TIME);
        `OFS_TARGET:     target_ff     <= sat(pwdata, MAX_FREQ);
        `OFS_RUN:        run_ff        <= pwdata[`RUN_BIT];
        default:         ;
      endcase
    end
  end

  // tracking result arrives from the power stage clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trk_meta_ff <= 1'b0;
      trk_sync_ff <= 1'b0;
    end else begin
      trk_meta_ff <= track_done;
      trk_sync_ff <= trk_meta_ff;
    end
  end

  // 0.1 ms tick paces the ramps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_div_ff  <= 32'h0000_0000;
      fast_tick_ff <= 1'b0;
    end else begin
      fast_tick_ff <= (fast_div_ff == FAST_CYC - 1);
      fast_div_ff  <= (fast_div_ff == FAST_CYC - 1) ? 32'h0000_0000 : fast_div_ff + 32'h0000_0001;
    end
  end

  // 10 ms phase timer restarts on every state change so a phase never runs short
  assign phase_new = (nxt_state != state_ff);
  assign slow_tick = (slow_div_ff == SLOW_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_div_ff  <= 32'h0000_0000;
      phase_cnt_ff <= 16'h0000;
    end else if (phase_new) begin
      slow_div_ff  <= 32'h0000_0000;
      phase_cnt_ff <= 16'h0000;
    end else begin
      slow_div_ff <= slow_tick ? 32'h0000_0000 : slow_div_ff + 32'h0000_0001;
      if (slow_tick && phase_cnt_ff != 16'hFFFF) begin
        phase_cnt_ff <= phase_cnt_ff + 16'h0001;
      end
    end
  end

  assign brake_done = (phase_cnt_ff >= brk_time_ff);
  assign hold_done  = ({16'h0000, phase_cnt_ff} >= {16'h0000, hold_ff} * {16'h0000, `HOLD_UNIT});
  assign go_ok      = (target_ff >= start_freq_ff);

  always_comb begin
    nxt_state = state_ff;
    if (!run_ff) begin
      nxt_state = ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE, ST_STANDBY: begin
          if (!go_ok) begin
            nxt_state = ST_STANDBY;
          end else if (method_ff == M_BRAKE && brk_time_ff != 16'h0000) begin
            nxt_state = ST_BRAKE;
          end else if (method_ff == M_TRACK) begin
            nxt_state = ST_TRACK;
          end else begin
            nxt_state = ST_HOLD;
          end
        end
        ST_BRAKE: if (brake_done) nxt_state = ST_HOLD;
        ST_TRACK: if (trk_sync_ff) nxt_state = ST_HOLD;
        ST_HOLD:  if (hold_done) nxt_state = ST_RAMP;
        ST_RAMP:  if (out_freq_ff == target_ff) nxt_state = ST_RUN;
        ST_RUN:   if (out_freq_ff != target_ff) nxt_state = ST_RAMP;
        default:  nxt_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ramp shaping: scale 0..full weights the slope; linear keeps it full
  assign dir_up       = (target_ff > out_freq_ff);
  assign ramp_restart = (nxt_state == ST_RAMP) &&
                        (state_ff != ST_RAMP || (dir_up != dir_up_ff && out_freq_ff != target_ff));
  assign remaining    = dir_up_ff ? target_ff - out_freq_ff : out_freq_ff - target_ff;
  assign prod         = {9'h000, MAX_FREQ} * {16'h0000, scale_ff};
  assign ramp_t       = dir_up_ff ? acc_time_ff : dec_time_ff;
  assign seg_t        = dir_up_ff ? (ease_out_ff ? s_acc_end_ff : s_acc_beg_ff)
                                  : (ease_out_ff ? s_dec_end_ff : s_dec_beg_ff);

  assign fq_if.tick   = fast_tick_ff;
  assign fq_if.clr    = ramp_restart || state_ff != ST_RAMP;
  assign fq_if.inc    = {15'h0000, prod[24:8]};
  assign fq_if.period = {16'h0000, ramp_t} * {16'h0000, `RAMP_UNIT};
  assign sc_if.tick   = fast_tick_ff;
  assign sc_if.clr    = ramp_restart || state_ff != ST_RAMP;
  assign sc_if.inc    = {23'h000000, `SCALE_FULL};
  assign sc_if.period = {16'h0000, seg_t} * {16'h0000, `RAMP_UNIT};

  rate_stepper #(.W(32)) u_freq_step (
    .pclk    (pclk),
    .presetn (presetn),
    .s       (fq_if.stepper)
  );

  rate_stepper #(.W(32)) u_scale_step (
    .pclk    (pclk),
    .presetn (presetn),
    .s       (sc_if.stepper)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scale_ff    <= `SCALE_FULL;
      dir_up_ff   <= 1'b1;
      ease_out_ff <= 1'b0;
      gain_ff     <= 16'h0000;
    end else if (!shape_ff) begin
      scale_ff    <= `SCALE_FULL;
      ease_out_ff <= 1'b0;
      gain_ff     <= 16'h0000;
      if (ramp_restart) dir_up_ff <= dir_up;
    end else if (ramp_restart) begin
      scale_ff    <= 9'h000;
      dir_up_ff   <= dir_up;
      ease_out_ff <= 1'b0;
      gain_ff     <= 16'h0000;
    end else if (state_ff == ST_RAMP) begin
      // ease out once the distance left matches what easing in took
      if (!ease_out_ff && gain_ff != 16'h0000 && remaining <= gain_ff) begin
        ease_out_ff <= 1'b1;
      end
      if (sc_if.step && !ease_out_ff && scale_ff < `SCALE_FULL) begin
        scale_ff <= scale_ff + 9'h001;
      end else if (sc_if.step && ease_out_ff && scale_ff > `SCALE_MIN) begin
        scale_ff <= scale_ff - 9'h001;
      end
      if (fq_if.step && !ease_out_ff && scale_ff < `SCALE_FULL) begin
        gain_ff <= gain_ff + 16'h0001;
      end
    end
  end

  // output frequency: start value unclamped, then stepped toward target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_freq_ff <= 16'h0000;
    end else if (nxt_state == ST_HOLD && state_ff != ST_HOLD) begin
      out_freq_ff <= start_freq_ff;
    end else if (state_ff == ST_RAMP && nxt_state == ST_RAMP && fq_if.step) begin
      out_freq_ff <= dir_up_ff ? out_freq_ff + 16'h0001 : out_freq_ff - 16'h0001;
    end else if (nxt_state != ST_HOLD && nxt_state != ST_RAMP && nxt_state != ST_RUN) begin
      out_freq_ff <= 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_en_ff  <= 1'b0;
      brake_en_ff  <= 1'b0;
      brake_cur_ff <= 16'h0000;
      track_req_ff <= 1'b0;
      standby_ff   <= 1'b0;
    end else begin
      drive_en_ff  <= (nxt_state == ST_HOLD || nxt_state == ST_RAMP || nxt_state == ST_RUN);
      brake_en_ff  <= (nxt_state == ST_BRAKE);
      brake_cur_ff <= (nxt_state == ST_BRAKE) ? brk_cur_ff : 16'h0000;
      track_req_ff <= (nxt_state == ST_TRACK);
      standby_ff   <= (nxt_state == ST_STANDBY);
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign out_freq  = out_freq_ff;
  assign drive_en  = drive_en_ff;
  assign brake_en  = brake_en_ff;
  assign brake_cur = brake_cur_ff;
  assign track_req = track_req_ff;
  assign standby   = standby_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_method_track: assert property (
    state_ff == ST_IDLE && run_ff && go_ok && method_ff == M_TRACK |=> state_ff == ST_TRACK)
    else $error("tracking start not taken");
  chk_first_freq: assert property (
    state_ff == ST_HOLD && $past(state_ff) != ST_HOLD |-> out_freq_ff == $past(start_freq_ff))
    else $error("first frequency differs from start frequency");
  chk_hold_stable: assert property (
    state_ff == ST_HOLD ##1 state_ff == ST_HOLD |-> $stable(out_freq_ff))
    else $error("frequency moved during hold");
  chk_standby_gate: assert property (
    run_ff && !go_ok && (state_ff == ST_IDLE || state_ff == ST_STANDBY) |=> standby_ff && !drive_en_ff)
    else $error("low target left standby");
  chk_start_unclamped: assert property (
    $rose(state_ff == ST_HOLD) && $past(start_freq_ff) != 16'h0000 |-> out_freq_ff != 16'h0000)
    else $error("start frequency suppressed");
  chk_brake_full: assert property (
    state_ff == ST_BRAKE ##1 state_ff == ST_HOLD |-> $past(phase_cnt_ff) >= $past(brk_time_ff))
    else $error("braking cut short");
  chk_brake_skip: assert property (
    state_ff == ST_IDLE && run_ff && go_ok && method_ff == M_BRAKE && brk_time_ff == 16'h0000
    |=> state_ff == ST_HOLD && !brake_en_ff)
    else $error("zero brake time still braked");
  chk_brake_current: assert property (
    brake_en_ff |-> state_ff == ST_BRAKE && brake_cur_ff == $past(brk_cur_ff) && brake_cur_ff <= `MAX_BRK_CUR)
    else $error("brake current wrong");
  chk_param_range: assert property (
    brk_time_ff <= `MAX_BRK_TIME && start_freq_ff <= `MAX_START_FREQ && hold_ff <= `MAX_HOLD)
    else $error("parameter out of range");
  chk_linear_full: assert property (
    !shape_ff && $past(!shape_ff) && state_ff == ST_RAMP |-> scale_ff == `SCALE_FULL)
    else $error("linear ramp slope scaled");
  chk_s_ease_in: assert property (
    shape_ff && state_ff == ST_RAMP && $past(state_ff) == ST_HOLD |-> scale_ff == 9'h000 && !ease_out_ff)
    else $error("S ramp did not ease in");
  chk_seg_range: assert property (
    s_acc_beg_ff <= `MAX_SEG && s_acc_end_ff <= `MAX_SEG && s_dec_beg_ff <= `MAX_SEG && s_dec_end_ff <= `MAX_SEG)
    else $error("segment time out of range");
  chk_no_overlap: assert property (
    state_ff == ST_HOLD |-> !brake_en_ff)
    else $error("braking overlaps hold");

  cov_brake_start: cover property (state_ff == ST_BRAKE ##1 state_ff == ST_HOLD);
  cov_s_reach_run: cover property (shape_ff && state_ff == ST_RAMP ##1 state_ff == ST_RUN);
  cov_standby:     cover property (state_ff == ST_STANDBY ##1 state_ff == ST_HOLD);
endmodule // drive_start_sequencer

// ### power_stage_model.sv
// power stage model: answers speed tracking requests
`timescale 1ns/1ps
module power_stage_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // tracking handshake
  input  wire logic track_req,
  output logic      track_done
);
  logic [5:0] cnt_ff;
  logic       slow_ff;

  // alternate a prompt and a slow answer so both latencies get exercised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff     <= 6'h00;
      slow_ff    <= 1'b0;
      track_done <= 1'b0;
    end else if (!track_req) begin
      cnt_ff     <= 6'h00;
      track_done <= 1'b0;
    end else if (cnt_ff == (slow_ff ? 6'h1E : 6'h02)) begin
      cnt_ff     <= cnt_ff + 6'h01;
      track_done <= 1'b1;
      slow_ff    <= ~slow_ff;
    end else begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end
endmodule // power_stage_model

// ### testbench.sv
// self-checking bench for the start sequencer
`timescale 1ns/1ps
`include "start_seq_map.svh"
module testbench import start_seq_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, err, saw_brk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, track_done, drive_en, brake_en, track_req, standby;
  logic [15:0] out_freq, brake_cur;
  int          n_fail, n_compared, seed, sf, wcnt, rcyc;
  int          mdl[13];
  int          mx[13] = '{65535, 5000, 500, 1000, 5000, 500, 500, 500, 500, 36000, 36000, 5000, 1};
  wire  [3:0]  mon = {standby, track_req, brake_en, drive_en};

  drive_start_sequencer #(.FAST_CYC(4), .SLOW_CYC(20)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .track_done(track_done), .out_freq(out_freq), .drive_en(drive_en), .brake_en(brake_en),
    .brake_cur(brake_cur), .track_req(track_req), .standby(standby));
  power_stage_model ps (.pclk(pclk), .presetn(presetn), .track_req(track_req), .track_done(track_done));

  always #5 pclk = ~pclk;

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task fail_out;
    n_fail++;
    print_verdict();
  endtask

  // signals move only right after an edge and are held until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_out();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // model keeps the saturated value that a read must return
  task wr(input int i, input int v);
    apb(1'b1, 12'(i * 4), 32'(v));
    mdl[i] = (v > mx[i]) ? mx[i] : v;
  endtask

  task rdchk(input int i);
    apb(1'b0, 12'(i * 4), 32'h0);
    chk("register", rd, 32'(mdl[i]));
  endtask

  task wait_bit(input int k, input logic v);
    wcnt = 0;
    saw_brk = 1'b0;
    while (mon[k] !== v) begin
      @(posedge pclk);
      wcnt++;
      saw_brk = saw_brk | brake_en;
      if (wcnt > 3000) fail_out();
    end
  endtask

  task ramp_to(input int tgt);
    int prev, bad, n, d;
    prev = out_freq;
    d = (tgt > prev) ? 1 : -1;
    bad = 0;
    n = 0;
    while (out_freq != tgt && n < 20000) begin
      @(posedge pclk);
      n++;
      if (out_freq != prev && out_freq != prev + d) bad = 1;
      prev = out_freq;
    end
    rcyc = n;
    chk("ramp steps", bad, 0);
    chk("ramp end", out_freq, tgt);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_fail = 0;
    n_compared = 0;
    seed = 32'h0f77;
    mdl = '{0, 50, 0, 0, 0, 1, 1, 1, 1, 100, 100, 0, 0};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 13; i++) rdchk(i);
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped error", err, 1);
    $display("test reset_values done");
    for (int i = 1; i < 9; i++) begin
      wr(i, 65535);
      rdchk(i);
    end
    $display("test saturation done");
    sf = 100 + ($random(seed) & 255);
    for (int i = 5; i < 9; i++) wr(i, 1);
    wr(1, sf);
    wr(2, 1);
    wr(3, 300);
    wr(4, 0);
    wr(9, 1);
    wr(10, 1);
    // target below start keeps standby; raising it starts directly
    wr(11, sf - 1);
    wr(0, 0);
    wr(12, 1);
    wait_bit(3, 1'b1);
    chk("standby drive", drive_en, 0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("standby state", rd[6:0], ST_STANDBY);
    wr(11, sf + 20);
    wait_bit(0, 1'b1);
    chk("start freq", out_freq, sf);
    repeat (190) @(posedge pclk);
    chk("held freq", out_freq, sf);
    ramp_to(sf + 20);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("run state", rd[6:0], ST_RUN);
    wr(12, 0);
    $display("test direct_start done");
    wr(2, 0);
    wr(0, 1);
    wr(4, 2);
    wr(12, 1);
    wait_bit(1, 1'b1);
    chk("brake current", brake_cur, 300);
    chk("no drive in brake", drive_en, 0);
    wait_bit(0, 1'b1);
    chk("brake time", (wcnt >= 36 && wcnt <= 46), 1);
    chk("brake released", brake_en, 0);
    chk("start after brake", out_freq, sf);
    wr(12, 0);
    // zero brake time must go straight to the start frequency
    wr(4, 0);
    wr(12, 1);
    wait_bit(0, 1'b1);
    chk("brake skipped", saw_brk, 0);
    wr(12, 0);
    $display("test brake_start done");
    wr(0, 2);
    repeat (2) begin
      wr(12, 1);
      wait_bit(2, 1'b1);
      wait_bit(0, 1'b1);
      chk("start after track", out_freq, sf);
      wr(12, 0);
    end
    $display("test track_start done");
    wr(0, 16);
    wr(11, sf + 15);
    wr(12, 1);
    wait_bit(0, 1'b1);
    ramp_to(sf + 15);
    // full slope is one step per 4-cycle tick; easing in and out must take well over that
    chk("s rise slower", rcyc > 15 * 4 * 2, 1);
    wr(11, sf + 5);
    ramp_to(sf + 5);
    chk("s fall slower", rcyc > 10 * 4 * 2, 1);
    wr(12, 0);
    $display("test s_curve done");
    print_verdict();
  end
endmodule // testbench
